//--- hdl/serial_pkg.sv
package serial_pkg;
  // =====================================
  // Widths and register map
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam logic [3:0] ADR_MODE = 4'h0;
  localparam logic [3:0] ADR_CTRL = 4'h1;
  localparam logic [3:0] ADR_RATE = 4'h2;
  localparam logic [3:0] ADR_TXD = 4'h3;
  localparam logic [3:0] ADR_RXD = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h5;
  localparam logic [3:0] ADR_ISTAT = 4'h6;
  localparam logic [3:0] ADR_IMASK = 4'h7;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // =====================================
  // Bit timing: 16 basic ticks per bit
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_SAMPLE = 4'h7;
  localparam logic [3:0] SCK_RISE = 4'h8;
  localparam logic [3:0] SYNC_BITS = 4'h8;
  localparam logic [3:0] FRAME_MIN = 4'h9;
  localparam logic [3:0] FRAME_MAX = 4'hc;
  // =====================================
  // Field layouts
  typedef struct packed {
    logic stop2;
    logic par_odd;
    logic par_en;
    logic char7;
    logic sync;
  } mode_type;
  typedef struct packed {
    logic tend;
    logic framing_error_flag;
    logic parity_error_flag;
    logic overrun_error_flag;
    logic rdrf;
    logic transmit_data_empty_flag;
  } stat_type;
  localparam stat_type STAT_RST = 6'h21;
  localparam logic [5:0] STAT_W1C = 6'h1e;
  typedef struct packed {
    logic tx_end;
    logic tx_empty;
    logic rx_err;
    logic rx_done;
  } irq_type;
endpackage : serial_pkg

//--- hdl/serial_tx.sv
`timescale 1ns/1ns
module serial_tx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic i_abort,
  input wire logic [7:0] i_data,
  input wire serial_pkg::mode_type i_mode,
  // Status and line
  output logic o_busy,
  output logic o_done,
  output logic o_smp,
  output logic o_txd,
  output logic o_sck
);
  typedef enum logic [0:0] {IDLE = 1'b0, RUN = 1'b1} st_type;
  st_type st_r, st_nxt;
  logic [11:0] sh_r, sh_nxt, frm;
  logic [3:0] tc_r, tc_nxt, idx_r, idx_nxt, len_r, len_nxt, len;
  logic txd_r, txd_nxt, sck_r, sck_nxt, par;
  logic [7:0] d;

  always_comb begin
    d = i_mode.char7 ? {1'b0, i_data[6:0]} : i_data;
    par = (^d) ^ i_mode.par_odd;
    frm = 12'hfff;
    if (i_mode.sync) begin
      frm[7:0] = d;
      len = serial_pkg::SYNC_BITS;
    end else begin
      frm[0] = 1'b0;
      frm[8:1] = d;
      if (i_mode.char7) begin
        frm[8] = i_mode.par_en ? par : 1'b1;
      end else begin
        frm[9] = i_mode.par_en ? par : 1'b1;
      end
      len = 4'(serial_pkg::FRAME_MIN + {3'h0, !i_mode.char7} + {3'h0, i_mode.par_en} + {3'h0, i_mode.stop2});
    end
  end

  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    tc_nxt = tc_r;
    idx_nxt = idx_r;
    len_nxt = len_r;
    o_done = 1'b0;
    o_smp = 1'b0;
    if (i_abort) begin
      st_nxt = IDLE;
    end else if (st_r == IDLE) begin
      if (i_start) begin
        st_nxt = RUN;
        sh_nxt = frm;
        len_nxt = len;
        tc_nxt = '0;
        idx_nxt = '0;
      end
    end else if (i_tick) begin
      tc_nxt = tc_r + 4'h1;
      o_smp = i_mode.sync && tc_r == serial_pkg::TICK_SAMPLE;
      if (tc_r == serial_pkg::TICK_LAST) begin
        sh_nxt = {1'b1, sh_r[11:1]};
        idx_nxt = idx_r + 4'h1;
        if (idx_r == len_r - 4'h1) begin
          st_nxt = IDLE;
          o_done = 1'b1;
        end
      end
    end
    txd_nxt = (st_nxt == RUN) ? sh_nxt[0] : 1'b1;
    sck_nxt = !(st_nxt == RUN && i_mode.sync && tc_nxt < serial_pkg::SCK_RISE);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= IDLE;
      sh_r <= 12'hfff;
      tc_r <= 4'h0;
      idx_r <= 4'h0;
      len_r <= 4'h0;
      txd_r <= 1'b1;
      sck_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      tc_r <= tc_nxt;
      idx_r <= idx_nxt;
      len_r <= len_nxt;
      txd_r <= txd_nxt;
      sck_r <= sck_nxt;
    end
  end

  assign o_busy = (st_r == RUN);
  assign o_txd = txd_r;
  assign o_sck = sck_r;

  frame_length_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_done && !i_mode.sync |-> len_r >= serial_pkg::FRAME_MIN && len_r <= serial_pkg::FRAME_MAX)
    else $error("async frame length outside 9 to 12 bits");
  abort_idle_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_abort |=> !o_busy && o_txd)
    else $error("transmitter not idle after abort");
endmodule : serial_tx

//--- hdl/serial_rx.sv
`timescale 1ns/1ns
module serial_rx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_en,
  input wire logic i_rxd,
  input wire logic i_sync_smp,
  input wire serial_pkg::mode_type i_mode,
  // Result
  output logic o_done,
  output logic [7:0] o_data,
  output logic o_per,
  output logic o_fer
);
  typedef enum logic [0:0] {IDLE = 1'b0, RUN = 1'b1} st_type;
  st_type st_r, st_nxt;
  logic [11:0] f_r, f_nxt;
  logic [3:0] tc_r, tc_nxt, idx_r, idx_nxt, last;
  logic [7:0] d;
  logic pb, sb, done_r, done_nxt;

  always_comb begin
    last = 4'(serial_pkg::FRAME_MIN - {3'h0, i_mode.char7} + {3'h0, i_mode.par_en});
    d = i_mode.char7 ? {1'b0, f_nxt[7:1]} : f_nxt[8:1];
    pb = i_mode.char7 ? f_nxt[8] : f_nxt[9];
    sb = f_nxt[last];
  end

  always_comb begin
    st_nxt = st_r;
    f_nxt = f_r;
    tc_nxt = tc_r;
    idx_nxt = idx_r;
    done_nxt = 1'b0;
    if (!i_en) begin
      st_nxt = IDLE;
      idx_nxt = '0;
    end else if (i_mode.sync) begin
      if (i_sync_smp) begin
        f_nxt[idx_r + 4'h1] = i_rxd;
        idx_nxt = idx_r + 4'h1;
        if (idx_r == serial_pkg::SYNC_BITS - 4'h1) begin
          idx_nxt = '0;
          done_nxt = 1'b1;
        end
      end
    end else if (i_tick) begin
      if (st_r == IDLE) begin
        if (!i_rxd) begin
          st_nxt = RUN;
          tc_nxt = '0;
          idx_nxt = '0;
        end
      end else begin
        tc_nxt = tc_r + 4'h1;
        if (tc_r == serial_pkg::TICK_SAMPLE) begin
          f_nxt[idx_r] = i_rxd;
          idx_nxt = idx_r + 4'h1;
          if (idx_r == 4'h0 && i_rxd) begin
            st_nxt = IDLE;
          end else if (idx_r == last) begin
            st_nxt = IDLE;
            done_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= IDLE;
      f_r <= 12'h000;
      tc_r <= 4'h0;
      idx_r <= 4'h0;
      o_data <= 8'h00;
      o_per <= 1'b0;
      o_fer <= 1'b0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      f_r <= f_nxt;
      tc_r <= tc_nxt;
      idx_r <= idx_nxt;
      done_r <= done_nxt;
      if (done_nxt) begin
        o_data <= i_mode.sync ? f_nxt[8:1] : d;
        o_per <= !i_mode.sync && i_mode.par_en && ((^d) ^ i_mode.par_odd) != pb;
        o_fer <= !i_mode.sync && !sb;
      end
    end
  end

  // Done follows the data register, so byte and flags are settled when it is seen
  assign o_done = done_r;

  start_align_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_en && !i_mode.sync && i_tick && st_r == IDLE && !i_rxd |=> st_r == RUN && tc_r == 4'h0)
    else $error("start edge did not realign bit timing");
  mid_sample_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_en && !i_mode.sync && st_r == RUN && idx_nxt != idx_r |-> i_tick && tc_r == serial_pkg::TICK_SAMPLE)
    else $error("bit sampled off the eighth tick");
  false_start_c: cover property (@(posedge i_clk) disable iff (i_rst)
    st_r == RUN && idx_r == 4'h0 ##1 st_r == IDLE);
endmodule : serial_rx

//--- hdl/serial_core.sv
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ns
module serial_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Serial pins
  input wire logic i_rxd,
  input wire logic i_sck,
  output logic o_sck,
  output logic o_sck_oe,
  output logic o_txd,
  output logic o_txd_en,
  // Interrupt
  output logic o_irq
);
  // =====================================
  // Register state
  serial_pkg::mode_type mode_r, mode_nxt;
  serial_pkg::stat_type stat_r, stat_nxt;
  serial_pkg::irq_type ist_r, ist_nxt, imask_r, imask_nxt, ev;
  logic te_r, te_nxt, re_r, re_nxt;
  logic [7:0] rate_r, rate_nxt, tdr_r, tdr_nxt, rdr_r, rdr_nxt, rdata_r, rdata_nxt;
  logic [7:0] bcnt_r, bcnt_nxt;
  logic rxd_s1_r, rxd_s2_r, sck_s1_r, sck_s2_r;
  logic tick, err_any, tx_start, tx_busy, tx_done, tx_smp, tx_line, tx_sck;
  logic rx_done, rx_per, rx_fer, rx_en;
  logic [7:0] rx_data;
  logic wr_stat;

  // =====================================
  // Pin synchronisers
  // Reset to the idle-high level so no false start edge follows reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rxd_s1_r <= 1'b1;
      rxd_s2_r <= 1'b1;
      sck_s1_r <= 1'b1;
      sck_s2_r <= 1'b1;
    end else begin
      rxd_s1_r <= i_rxd;
      rxd_s2_r <= rxd_s1_r;
      sck_s1_r <= i_sck;
      sck_s2_r <= sck_s1_r;
    end
  end

  // =====================================
  // Basic clock: one tick per (rate+1) cycles, 16 ticks a bit
  // Rate zero ticks every cycle: the fastest bit is 16 clocks
  always_comb begin
    tick = (bcnt_r == rate_r);
    bcnt_nxt = tick ? 8'h00 : bcnt_r + 8'h01;
  end

  // =====================================
  // Engines
  assign err_any = stat_r.overrun_error_flag | stat_r.parity_error_flag | stat_r.framing_error_flag;
  // Error flags hold off reception until cleared, so no byte lands on stale status
  assign rx_en = re_r && !err_any;
  assign tx_start = te_r && !stat_r.transmit_data_empty_flag && !tx_busy && !(mode_r.sync && err_any);

  // Clearing the transmit enable is the initialization: the frame is dropped at once
  serial_tx u_tx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_start(tx_start),
    .i_abort(!te_r),
    .i_data(tdr_r),
    .i_mode(mode_r),
    .o_busy(tx_busy),
    .o_done(tx_done),
    .o_smp(tx_smp),
    .o_txd(tx_line),
    .o_sck(tx_sck)
  );

  // Sync receive borrows the transmit sample strobe, so it only runs while sending
  serial_rx u_rx (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_tick(tick),
    .i_en(rx_en),
    .i_rxd(rxd_s2_r),
    .i_sync_smp(tx_smp),
    .i_mode(mode_r),
    .o_done(rx_done),
    .o_data(rx_data),
    .o_per(rx_per),
    .o_fer(rx_fer)
  );

  // =====================================
  // Register writes and hardware events
  always_comb begin
    mode_nxt = mode_r;
    te_nxt = te_r;
    re_nxt = re_r;
    rate_nxt = rate_r;
    tdr_nxt = tdr_r;
    rdr_nxt = rdr_r;
    imask_nxt = imask_r;
    wr_stat = i_wr && i_addr == serial_pkg::ADR_STAT;
    if (i_wr) begin
      unique case (i_addr)
        serial_pkg::ADR_MODE: mode_nxt = serial_pkg::mode_type'(i_wdata[4:0]);
        serial_pkg::ADR_CTRL: begin
          te_nxt = i_wdata[0];
          re_nxt = i_wdata[1];
        end
        serial_pkg::ADR_RATE: rate_nxt = i_wdata;
        serial_pkg::ADR_TXD: tdr_nxt = i_wdata;
        serial_pkg::ADR_IMASK: imask_nxt = serial_pkg::irq_type'(i_wdata[3:0]);
        default: ;
      endcase
    end
    // Clears from software first; hardware sets below win the same cycle
    stat_nxt = stat_r;
    if (wr_stat) begin
      stat_nxt = stat_r & ~(i_wdata[5:0] & serial_pkg::STAT_W1C);
    end
    // A new byte also withdraws the end-of-frame flag
    if (i_wr && i_addr == serial_pkg::ADR_TXD) begin
      stat_nxt.transmit_data_empty_flag = 1'b0;
      stat_nxt.tend = 1'b0;
    end
    ev = '0;
    if (tx_start) begin
      stat_nxt.transmit_data_empty_flag = 1'b1;
      ev.tx_empty = 1'b1;
    end
    if (tx_done && stat_r.transmit_data_empty_flag) begin
      stat_nxt.tend = 1'b1;
      ev.tx_end = 1'b1;
    end
    if (rx_done) begin
      // Overrun keeps the older byte; the newer one is lost
      if (stat_r.rdrf) begin
        stat_nxt.overrun_error_flag = 1'b1;
        ev.rx_err = 1'b1;
      end else begin
        rdr_nxt = rx_data;
        if (rx_per || rx_fer) begin
          stat_nxt.parity_error_flag = stat_nxt.parity_error_flag | rx_per;
          stat_nxt.framing_error_flag = stat_nxt.framing_error_flag | rx_fer;
          ev.rx_err = 1'b1;
        end else begin
          stat_nxt.rdrf = 1'b1;
          ev.rx_done = 1'b1;
        end
      end
    end
    ist_nxt = ist_r;
    if (i_wr && i_addr == serial_pkg::ADR_ISTAT) begin
      ist_nxt = ist_r & ~serial_pkg::irq_type'(i_wdata[3:0]);
    end
    ist_nxt = ist_nxt | ev;
  end

  // =====================================
  // Read port: one cycle latency; shift register has no address
  // Reads have no side effects; receive and error flags clear only by writing ones, the two transmit flags only by a TXD write
  always_comb begin
    rdata_nxt = serial_pkg::READ_ZERO;
    if (i_rd) begin
      unique case (i_addr)
        serial_pkg::ADR_MODE: rdata_nxt = {3'h0, mode_r};
        serial_pkg::ADR_CTRL: rdata_nxt = {6'h00, re_r, te_r};
        serial_pkg::ADR_RATE: rdata_nxt = rate_r;
        serial_pkg::ADR_TXD: rdata_nxt = tdr_r;
        serial_pkg::ADR_RXD: rdata_nxt = rdr_r;
        serial_pkg::ADR_STAT: rdata_nxt = {2'h0, stat_r};
        serial_pkg::ADR_ISTAT: rdata_nxt = {4'h0, ist_r};
        serial_pkg::ADR_IMASK: rdata_nxt = {4'h0, imask_r};
        default: rdata_nxt = serial_pkg::READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_r <= '0;
      stat_r <= serial_pkg::STAT_RST;
      ist_r <= '0;
      imask_r <= '0;
      te_r <= 1'b0;
      re_r <= 1'b0;
      rate_r <= serial_pkg::RATE_RST;
      tdr_r <= 8'h00;
      rdr_r <= 8'h00;
      rdata_r <= 8'h00;
      bcnt_r <= 8'h00;
    end else begin
      mode_r <= mode_nxt;
      stat_r <= stat_nxt;
      ist_r <= ist_nxt;
      imask_r <= imask_nxt;
      te_r <= te_nxt;
      re_r <= re_nxt;
      rate_r <= rate_nxt;
      tdr_r <= tdr_nxt;
      rdr_r <= rdr_nxt;
      rdata_r <= rdata_nxt;
      bcnt_r <= bcnt_nxt;
    end
  end

  // =====================================
  // Pins and interrupt
  // The interrupt is a level: it stays high until software clears the cause
  // Clock pin is driven only in synchronous mode; external clock input is not used
  assign o_sck = tx_sck;
  assign o_sck_oe = mode_r.sync;
  assign o_txd = te_r ? tx_line : 1'b0;
  assign o_txd_en = te_r;
  assign o_irq = |(ist_r & imask_r);
  assign o_rdata = rdata_r;

  // =====================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  rdr_load_a: assert property (
    rx_done && !stat_r.rdrf |=> rdr_r == $past(rx_data))
    else $error("received byte not moved to holding register");
  rdr_read_a: assert property (
    i_rd && i_addr == serial_pkg::ADR_RXD |=> o_rdata == $past(rdr_r))
    else $error("holding register read wrong");
  sync_err_block_a: assert property (
    mode_r.sync && err_any && !tx_busy |=> !tx_busy)
    else $error("transmit started with receive error set");
  re_keep_errs_a: assert property (
    re_r && !re_nxt && !wr_stat && err_any |=> {stat_r.overrun_error_flag, stat_r.parity_error_flag, stat_r.framing_error_flag} ==
      $past({stat_r.overrun_error_flag, stat_r.parity_error_flag, stat_r.framing_error_flag}))
    else $error("error flags changed by receiver disable");
  baud_tick_a: assert property (
    tick && rate_r == $past(rate_r) |=> bcnt_r == 8'h00 && !tick || rate_r == 8'h00)
    else $error("basic clock divider misbehaves");
  sck_dir_a: assert property (
    !mode_r.sync |-> !o_sck_oe && o_sck)
    else $error("clock pin driven in async mode");
  tx_init_a: assert property (
    !te_r |-> !o_txd && !o_txd_en)
    else $error("transmit pin not released at zero");
  irq_level_a: assert property (
    |(ev & imask_r) && !(i_wr && i_addr == serial_pkg::ADR_IMASK) |=> o_irq)
    else $error("unmasked event did not raise the interrupt");

  // =====================================
  // Status and line checks
  // Clock pin is only read back; an externally clocked mode is not offered
  sck_echo_a: assert property (
    mode_r.sync && $past(mode_r.sync) && $past(mode_r.sync, 2) |-> sck_s2_r == $past(o_sck, 2))
    else $error("clock pin readback differs from drive");
  sck_idle_a: assert property (
    !tx_busy |-> o_sck)
    else $error("clock pin moved outside a frame");
  transmit_data_empty_flag_hold_a: assert property (
    mode_r.sync && err_any && !stat_r.transmit_data_empty_flag |=> !stat_r.transmit_data_empty_flag)
    else $error("empty flag set while transmit is blocked");
  err_sticky_a: assert property (
    !wr_stat |=> ($past({stat_r.overrun_error_flag, stat_r.parity_error_flag, stat_r.framing_error_flag}) & ~{stat_r.overrun_error_flag, stat_r.parity_error_flag, stat_r.framing_error_flag}) == 3'h0)
    else $error("error flag fell without a status write");
  tx_take_a: assert property (
    tx_start |=> stat_r.transmit_data_empty_flag && tx_busy)
    else $error("transmit data not taken");
  rd_idle_a: assert property (
    !i_rd |=> o_rdata == serial_pkg::READ_ZERO)
    else $error("read data stands beyond one cycle");
  rdrf_set_a: assert property (
    ev.rx_done |=> stat_r.rdrf)
    else $error("full flag not set after a good byte");
  fer_flag_a: assert property (
    rx_done && !stat_r.rdrf && rx_fer |=> stat_r.framing_error_flag && !stat_r.rdrf)
    else $error("framing error not flagged");
  txd_idle_a: assert property (
    te_r && !tx_busy |-> o_txd)
    else $error("transmit line not idle high");

  rx_byte_c: cover property (rx_done && !stat_r.rdrf);
  overrun_c: cover property (rx_done && stat_r.rdrf);
  tx_frame_c: cover property (tx_start ##[1:1000] tx_done);
  sync_hold_c: cover property (mode_r.sync && err_any && !stat_r.transmit_data_empty_flag);
endmodule : serial_core

//--- sim/serial_peer.sv
`timescale 1ns/1ns
// ==========================
// Remote peer: sends async frames, decodes the transmit pin
module serial_peer (
  // Line
  input wire logic i_txd,
  input wire logic i_txd_en,
  input wire logic i_sck,
  output logic o_rxd,
  output logic o_sck,
  // Decoded frame
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_good
);
  int bit_ns = 320;
  int nbits = 8;
  int sn = 0;
  logic par_en = 1'b0;
  logic par_odd = 1'b0;
  logic stop2 = 1'b0;
  logic sync = 1'b0;
  logic busy = 1'b0;
  logic ok;
  logic [7:0] ad;
  logic [7:0] sd = 8'h00;
  initial begin
    o_rxd = 1'b1;
    o_sck = 1'b1;
    o_valid = 1'b0;
    o_data = 8'h00;
    o_good = 1'b0;
  end
  // Link clock stands still between frames
  always #80 o_sck = busy ? ~o_sck : 1'b1;
  // ==========================
  // Frame sender
  task automatic send(input logic [7:0] d, input logic bad_stop);
    logic q[$];
    q = {1'b0};
    for (int i = 0; i < nbits; i++) q.push_back(d[i]);
    if (par_en) q.push_back(^(d & (nbits == 8 ? 8'hff : 8'h7f)) ^ par_odd);
    q.push_back(~bad_stop);
    if (stop2) q.push_back(1'b1);
    // Off the clock edge so the pin never races the synchroniser
    #7;
    busy = 1'b1;
    for (int i = 0; i < q.size(); i++) begin
      o_rxd = q[i];
      #(bit_ns - 60);
      // Edge noise on data bits: only a mid-bit sample survives it
      if (i > 0 && i <= nbits) o_rxd = ~q[i];
      #60;
    end
    o_rxd = 1'b1;
    busy = 1'b0;
  endtask : send
  task automatic glitch;
    #7;
    o_rxd = 1'b0;
    #60;
    o_rxd = 1'b1;
  endtask : glitch
  // ==========================
  // Async decoder of the transmit pin
  initial forever begin
    @(negedge i_txd iff (i_txd_en && !sync));
    #(bit_ns / 2);
    ok = ~i_txd;
    ad = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      #(bit_ns);
      ad[i] = i_txd;
    end
    if (par_en) begin
      #(bit_ns);
      ok = ok & (i_txd == (^ad ^ par_odd));
    end
    repeat (stop2 ? 2 : 1) begin
      #(bit_ns);
      ok = ok & i_txd;
    end
    o_data = ad;
    o_good = ok;
    o_valid = 1'b1;
    #20;
    o_valid = 1'b0;
  end
  // Sync decoder, LSB first on clock rise
  always @(posedge i_sck) begin
    if (sync) begin
      sd = {i_txd, sd[7:1]};
      sn++;
      if (sn == 8) begin
        sn = 0;
        o_data = sd;
        o_good = 1'b1;
        o_valid = 1'b1;
        #20;
        o_valid = 1'b0;
      end
    end
  end
endmodule : serial_peer

//--- sim/testbench.sv
`timescale 1ns/1ns
// ==========================
// Register-port bench with a remote peer on the pins
module testbench;
  typedef struct {logic [7:0] e; logic [7:0] m; string n;} note_type;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata, d, m, fe, pd;
  logic o_sck, o_sck_oe, o_txd, o_txd_en, o_irq, rxd, psck, pv, pg;
  logic [4:0] md [4] = '{5'h00, 5'h02, 5'h0c, 5'h14};
  int miscompares = 0;
  int n_checks = 0;
  int frames = 0;
  int seed;
  note_type rq[$];
  logic [7:0] tq[$];
  wire sck_w = o_sck_oe ? o_sck : psck;
  initial forever #10 i_clk = ~i_clk;
  serial_core DUT (.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd), .i_sck(sck_w), .o_sck(o_sck), .o_sck_oe(o_sck_oe),
    .o_txd(o_txd), .o_txd_en(o_txd_en), .o_irq(o_irq));
  serial_peer peer (.i_txd(o_txd), .i_txd_en(o_txd_en), .i_sck(sck_w), .o_rxd(rxd), .o_sck(psck),
    .o_valid(pv), .o_data(pd), .o_good(pg));
  // ==========================
  // Tasks
  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    n_checks++;
    if (g !== x) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] x, input logic [7:0] mk, input string n);
    note_type t;
    t.e = x;
    t.m = mk;
    t.n = n;
    rq.push_back(t);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
  endtask : rd
  task automatic wait_frame;
    int n0;
    n0 = frames;
    for (int i = 0; i < 600 && frames == n0; i++) @(posedge i_clk);
    chk("frame seen", 8'h01, {7'h00, frames != n0});
    // Let the last stop bit finish before touching the mode
    repeat (20) @(posedge i_clk);
  endtask : wait_frame
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // ==========================
  // Monitors: read data one cycle after the strobe, decoded frames
  always @(posedge i_clk) begin
    if (rd_d) begin
      if (rq.size() == 0) chk("unexpected read", 8'h00, 8'hff);
      else chk(rq[0].n, rq[0].e & rq[0].m, o_rdata & rq[0].m);
      if (rq.size() > 0) void'(rq.pop_front());
    end
    rd_d <= i_rd;
  end
  always @(posedge pv) begin
    frames++;
    if (tq.size() > 0) begin
      fe = tq.pop_front();
      chk("frame data", fe, pd);
      chk("frame shape", 8'h01, {7'h00, pg});
    end
  end
  initial begin
    #400000;
    miscompares++;
    print_verdict();
  end
  // ==========================
  // Main sequence
  initial begin
    seed = $urandom(9);
    repeat (10) @(posedge i_clk);
    @(negedge i_clk);
    chk("reset pins", 8'h10, {3'h0, o_sck, o_sck_oe, o_txd, o_txd_en, o_irq});
    @(posedge i_clk);
    i_rst <= 1'b0;
    rd(serial_pkg::ADR_STAT, 8'h21, 8'hff, "stat reset");
    rd(serial_pkg::ADR_RATE, 8'h00, 8'hff, "rate reset");
    for (int a = 8; a < 16; a++) rd(4'(a), 8'h00, 8'hff, "unmapped");
    $display("test reset done");
    wr(serial_pkg::ADR_CTRL, 8'h03);
    for (int k = 0; k < 4; k++) begin
      wr(serial_pkg::ADR_MODE, {3'h0, md[k]});
      peer.nbits = md[k][1] ? 7 : 8;
      peer.par_en = md[k][2];
      peer.par_odd = md[k][3];
      peer.stop2 = md[k][4];
      m = md[k][1] ? 8'h7f : 8'hff;
      d = 8'($urandom());
      peer.send(d, 1'b0);
      rd(serial_pkg::ADR_RXD, d, m, "rx data");
      rd(serial_pkg::ADR_STAT, 8'h02, 8'h1e, "rx status");
      wr(serial_pkg::ADR_STAT, 8'h02);
      d = 8'($urandom());
      tq.push_back(d & m);
      wr(serial_pkg::ADR_TXD, d);
      wait_frame();
    end
    $display("test async modes done");
    chk("irq masked", 8'h00, {7'h00, o_irq});
    wr(serial_pkg::ADR_IMASK, 8'h01);
    repeat (2) @(negedge i_clk);
    chk("irq raised", 8'h01, {7'h00, o_irq});
    wr(serial_pkg::ADR_ISTAT, 8'h0f);
    repeat (2) @(negedge i_clk);
    chk("irq cleared", 8'h00, {7'h00, o_irq});
    peer.glitch();
    repeat (40) @(posedge i_clk);
    rd(serial_pkg::ADR_STAT, 8'h00, 8'h02, "false start");
    $display("test irq and false start done");
    wr(serial_pkg::ADR_MODE, 8'h00);
    peer.nbits = 8;
    peer.par_en = 1'b0;
    peer.stop2 = 1'b0;
    wr(serial_pkg::ADR_IMASK, 8'h02);
    peer.send(8'($urandom()), 1'b1);
    rd(serial_pkg::ADR_STAT, 8'h10, 8'h1e, "framing flag");
    rd(serial_pkg::ADR_ISTAT, 8'h02, 8'h02, "rx error event");
    chk("irq error", 8'h01, {7'h00, o_irq});
    wr(serial_pkg::ADR_CTRL, 8'h01);
    rd(serial_pkg::ADR_STAT, 8'h10, 8'h10, "flag after disable");
    $display("test framing done");
    wr(serial_pkg::ADR_RATE, 8'h01);
    rd(serial_pkg::ADR_RATE, 8'h01, 8'hff, "rate value");
    wr(serial_pkg::ADR_MODE, 8'h01);
    peer.sync = 1'b1;
    repeat (2) @(negedge i_clk);
    chk("clock pin drive", 8'h01, {7'h00, o_sck_oe});
    d = 8'($urandom());
    wr(serial_pkg::ADR_TXD, d);
    repeat (400) @(posedge i_clk);
    rd(serial_pkg::ADR_STAT, 8'h00, 8'h01, "blocked send");
    tq.push_back(d);
    wr(serial_pkg::ADR_STAT, 8'h10);
    wait_frame();
    peer.sync = 1'b0;
    wr(serial_pkg::ADR_MODE, 8'h00);
    $display("test sync interlock done");
    wr(serial_pkg::ADR_TXD, 8'($urandom()));
    repeat (60) @(posedge i_clk);
    wr(serial_pkg::ADR_CTRL, 8'h00);
    repeat (2) @(negedge i_clk);
    chk("abort pin", 8'h00, {6'h00, o_txd, o_txd_en});
    repeat (300) @(posedge i_clk);
    $display("test abort done");
    print_verdict();
  end
endmodule : testbench
